// *** rtl/meter_cmd_pkg.sv ***
`default_nettype none
package meter_cmd_pkg;
    // ****************************************
    // Request codes
    // ****************************************
    localparam logic [7:0] MAIN_VAR     = 8'h01;
    localparam logic [7:0] SUB_READ     = 8'h01;
    localparam logic [7:0] SUB_WRITE    = 8'h02;
    localparam logic [7:0] MAIN_OP      = 8'h30;
    localparam logic [7:0] SUB_OP       = 8'h05;
    localparam logic [7:0] INS_PERMIT   = 8'h00;
    localparam logic [7:0] INS_FZERO    = 8'h03;
    localparam logic [7:0] INS_SRESET   = 8'h06;
    localparam logic [7:0] INS_AREA1    = 8'h07;
    localparam logic [7:0] INS_PROTECT  = 8'h08;
    localparam logic [7:0] REL_OFF      = 8'h00;
    localparam logic [7:0] REL_ON       = 8'h01;
    localparam logic [7:0] VT_C0        = 8'hc0;
    localparam logic [7:0] VT_C1        = 8'hc1;
    localparam logic [7:0] VT_C2        = 8'hc2;
    localparam logic [7:0] VT_C3        = 8'hc3;
    localparam logic [15:0] VA_PV       = 16'h0001;
    localparam logic [15:0] VA_STAT     = 16'h0002;
    localparam logic [15:0] VA_REMOTE   = 16'h0000;
    localparam logic [7:0] BITPOS_NONE  = 8'h00;
    localparam logic [7:0] ONE_ELEM     = 8'h01;
    // Frame lengths in characters, codes included
    localparam logic [7:0] LEN_OP       = 8'h08;
    localparam logic [7:0] LEN_RD       = 8'h10;
    localparam logic [7:0] LEN_WR       = 8'h18;
    // ****************************************
    // Result codes
    // ****************************************
    localparam logic [15:0] RES_OK      = 16'h0000;
    localparam logic [15:0] RES_LONG    = 16'h1001;
    localparam logic [15:0] RES_SHORT   = 16'h1002;
    localparam logic [15:0] RES_COUNT   = 16'h1003;
    localparam logic [15:0] RES_PARAM   = 16'h1100;
    localparam logic [15:0] RES_VTYPE   = 16'h1101;
    localparam logic [15:0] RES_ADDR    = 16'h1103;
    localparam logic [15:0] RES_RDONLY  = 16'h3003;
    localparam logic [15:0] RES_OPERR   = 16'h2203;
    localparam logic [31:0] UNKNOWN_DAT = 32'hffffffff;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_CODE     = 8'h04;
    localparam logic [7:0] REG_ARG      = 8'h08;
    localparam logic [7:0] REG_LEN      = 8'h0c;
    localparam logic [7:0] REG_WDATA    = 8'h10;
    localparam logic [7:0] REG_RESP     = 8'h14;
    localparam logic [7:0] REG_RDATA    = 8'h18;
    localparam logic [7:0] REG_STATE    = 8'h1c;
    localparam int CTRL_GO    = 0;
    localparam int F_AREA     = 0;
    localparam int F_PERMIT   = 1;
    localparam int F_FZERO    = 2;
    localparam int F_PROT     = 3;
    localparam int F_DONE     = 4;
    localparam int F_BUSY     = 5;
    localparam int F_CALIB    = 6;
    localparam int F_INIT     = 7;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_REPLY = 3'b100
    } cmd_state_e;

    function automatic logic [15:0] len_code(input logic [7:0] len,
                                             input logic [7:0] need,
                                             input logic [15:0] over);
        if (len < need)
            return RES_SHORT;
        else if (len > need)
            return over;
        else
            return RES_OK;
    endfunction
endpackage
`default_nettype wire

// *** rtl/op_check.sv ***
`default_nettype none
module op_check (
    input  wire logic [7:0]  instr,
    input  wire logic [7:0]  related,
    input  wire logic [7:0]  frame_len,
    input  wire logic        calib,
    input  wire logic        permit,
    input  wire logic        area1,
    input  wire logic        nvm_fail,
    output logic      [15:0] result
);
    logic [15:0] len_r;
    logic        rel_ok;
    logic        need_permit;
    logic        state_bad;
    logic        nvm_use;

    always_comb begin
        len_r = meter_cmd_pkg::len_code(frame_len, meter_cmd_pkg::LEN_OP,
                                        meter_cmd_pkg::RES_LONG);
        case (instr)
            meter_cmd_pkg::INS_PERMIT,
            meter_cmd_pkg::INS_FZERO: begin
                rel_ok = (related == meter_cmd_pkg::REL_OFF)
                      || (related == meter_cmd_pkg::REL_ON);
            end
            meter_cmd_pkg::INS_SRESET,
            meter_cmd_pkg::INS_AREA1,
            meter_cmd_pkg::INS_PROTECT: begin
                rel_ok = (related == meter_cmd_pkg::REL_OFF);
            end
            default: begin
                rel_ok = 1'b0;
            end
        endcase
        // Only the permission switch itself works without permission
        need_permit = (instr != meter_cmd_pkg::INS_PERMIT);
        // Forced-zero and protect level only make sense while measuring
        state_bad = area1 && ((instr == meter_cmd_pkg::INS_FZERO)
                           || (instr == meter_cmd_pkg::INS_PROTECT));
        nvm_use = (instr == meter_cmd_pkg::INS_PERMIT)
               || (instr == meter_cmd_pkg::INS_FZERO);
        if (len_r != meter_cmd_pkg::RES_OK)
            result = len_r;
        else if (!rel_ok)
            result = meter_cmd_pkg::RES_PARAM;
        else if (calib)
            result = meter_cmd_pkg::RES_OPERR;
        else if (need_permit && !permit)
            result = meter_cmd_pkg::RES_OPERR;
        else if (state_bad)
            result = meter_cmd_pkg::RES_OPERR;
        else if (nvm_use && nvm_fail)
            result = meter_cmd_pkg::RES_OPERR;
        else
            result = meter_cmd_pkg::RES_OK;
    end
endmodule // op_check
`default_nettype wire

// *** rtl/meter_operation_command_handler.sv ***
// Local design decisions: register access over Wishbone and the placing of the registers.
`default_nettype none
module meter_operation_command_handler (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        panel_init,
    input  wire logic        calib_level,
    input  wire logic        nvm_fail,
    input  wire logic [31:0] process_value,
    input  wire logic [31:0] comp_status,
    output logic             setting_area,
    output logic             measuring,
    output logic             write_permit,
    output logic             forced_zero,
    output logic             protect_level,
    output logic             init_level_ind,
    output logic             soft_reset,
    output logic      [31:0] display_value,
    output logic             param_wr,
    output logic      [23:0] param_sel,
    output logic      [31:0] param_data
);
    // ****************************************
    // Bus slave
    // ****************************************
    logic        ack_q;
    logic        wr_take;
    logic [31:0] rd_d;
    logic [31:0] dat_q;
    logic [15:0] code_q;
    logic [31:0] arg_q;
    logic [15:0] len_q;
    logic [31:0] wdata_q;
    logic [31:0] resp_q;
    logic [31:0] rdata_q;
    logic        done_q;
    logic        go;
    logic [31:0] code_m;
    logic [31:0] len_m;
    meter_cmd_pkg::cmd_state_e state_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // Narrow registers merged at full width, then cut back
    assign code_m = merge({16'h0000, code_q}, dat_i, sel_i);
    assign len_m  = merge({16'h0000, len_q}, dat_i, sel_i);

    // Writes land on the edge where the master sees ack
    assign wr_take = cyc_i && stb_i && we_i && ack_q;
    assign go = wr_take && (adr_i == meter_cmd_pkg::REG_CTRL)
             && sel_i[0] && dat_i[meter_cmd_pkg::CTRL_GO];
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    always_ff @(posedge clock) begin
        if (rst)
            ack_q <= 1'b0;
        else
            ack_q <= cyc_i && stb_i && !ack_q;
    end

    always_comb begin
        case (adr_i)
            meter_cmd_pkg::REG_CODE:  rd_d = {16'h0000, code_q};
            meter_cmd_pkg::REG_ARG:   rd_d = arg_q;
            meter_cmd_pkg::REG_LEN:   rd_d = {16'h0000, len_q};
            meter_cmd_pkg::REG_WDATA: rd_d = wdata_q;
            meter_cmd_pkg::REG_RESP:  rd_d = resp_q;
            meter_cmd_pkg::REG_RDATA: rd_d = rdata_q;
            meter_cmd_pkg::REG_STATE: begin
                rd_d = 32'h00000000;
                rd_d[meter_cmd_pkg::F_AREA]   = setting_area;
                rd_d[meter_cmd_pkg::F_PERMIT] = write_permit;
                rd_d[meter_cmd_pkg::F_FZERO]  = forced_zero;
                rd_d[meter_cmd_pkg::F_PROT]   = protect_level;
                rd_d[meter_cmd_pkg::F_DONE]   = done_q;
                rd_d[meter_cmd_pkg::F_BUSY]   = (state_q != meter_cmd_pkg::ST_IDLE);
                rd_d[meter_cmd_pkg::F_CALIB]  = calib_level;
                rd_d[meter_cmd_pkg::F_INIT]   = init_level_ind;
            end
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst)
            dat_q <= 32'h00000000;
        else if (cyc_i && stb_i && !ack_q)
            dat_q <= rd_d;
    end

    // Request fields freeze while a command runs
    always_ff @(posedge clock) begin
        if (rst) begin
            code_q  <= 16'h0000;
            arg_q   <= 32'h00000000;
            len_q   <= 16'h0000;
            wdata_q <= 32'h00000000;
        end else if (wr_take && state_q == meter_cmd_pkg::ST_IDLE) begin
            if (adr_i == meter_cmd_pkg::REG_CODE)
                code_q <= code_m[15:0];
            if (adr_i == meter_cmd_pkg::REG_ARG)
                arg_q <= merge(arg_q, dat_i, sel_i);
            if (adr_i == meter_cmd_pkg::REG_LEN)
                len_q <= len_m[15:0];
            if (adr_i == meter_cmd_pkg::REG_WDATA)
                wdata_q <= merge(wdata_q, dat_i, sel_i);
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= meter_cmd_pkg::ST_IDLE;
        end else begin
            case (state_q)
                // A start while busy is dropped, never queued
                meter_cmd_pkg::ST_IDLE:  if (go) state_q <= meter_cmd_pkg::ST_EXEC;
                meter_cmd_pkg::ST_EXEC:  state_q <= meter_cmd_pkg::ST_REPLY;
                meter_cmd_pkg::ST_REPLY: state_q <= meter_cmd_pkg::ST_IDLE;
                default:                 state_q <= meter_cmd_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Decode and check
    // ****************************************
    logic [7:0]  main_request_code;
    logic [7:0]  sub_request_code;
    logic [7:0]  vtype;
    logic [7:0]  related;
    logic [15:0] vaddr;
    logic [7:0]  flen;
    logic [7:0]  elems;
    logic        is_op;
    logic        is_rd;
    logic        is_wr;
    logic        exec;
    logic [15:0] op_res;
    logic [15:0] res_d;
    logic [31:0] rdat_d;
    logic        fields_ok;

    assign main_request_code = code_q[15:8];
    assign sub_request_code  = code_q[7:0];
    assign vtype   = arg_q[7:0];
    assign related = arg_q[15:8];
    assign vaddr   = arg_q[31:16];
    assign flen    = len_q[7:0];
    assign elems   = len_q[15:8];
    assign is_op = (main_request_code == meter_cmd_pkg::MAIN_OP)
                && (sub_request_code == meter_cmd_pkg::SUB_OP);
    assign is_rd = (main_request_code == meter_cmd_pkg::MAIN_VAR)
                && (sub_request_code == meter_cmd_pkg::SUB_READ);
    assign is_wr = (main_request_code == meter_cmd_pkg::MAIN_VAR)
                && (sub_request_code == meter_cmd_pkg::SUB_WRITE);
    assign exec = (state_q == meter_cmd_pkg::ST_EXEC);
    assign fields_ok = (related == meter_cmd_pkg::BITPOS_NONE)
                    && (elems == meter_cmd_pkg::ONE_ELEM);

    op_check u_op_check (
        .instr     (vtype),
        .related   (related),
        .frame_len (flen),
        .calib     (calib_level),
        .permit    (write_permit),
        .area1     (setting_area),
        .nvm_fail  (nvm_fail),
        .result    (op_res)
    );

    always_comb begin
        rdat_d = 32'h00000000;
        res_d  = meter_cmd_pkg::RES_PARAM;
        if (is_op) begin
            res_d = op_res;
        end else if (is_rd) begin
            res_d = meter_cmd_pkg::len_code(flen, meter_cmd_pkg::LEN_RD,
                                            meter_cmd_pkg::RES_LONG);
            if (res_d != meter_cmd_pkg::RES_OK)
                res_d = res_d;
            else if (vtype != meter_cmd_pkg::VT_C0)
                res_d = meter_cmd_pkg::RES_VTYPE;
            else if (!fields_ok)
                res_d = meter_cmd_pkg::RES_PARAM;
            else if (vaddr == meter_cmd_pkg::VA_PV)
                rdat_d = setting_area ? meter_cmd_pkg::UNKNOWN_DAT : process_value;
            else if (vaddr == meter_cmd_pkg::VA_STAT)
                rdat_d = setting_area ? meter_cmd_pkg::UNKNOWN_DAT : comp_status;
            else
                res_d = meter_cmd_pkg::RES_ADDR;
        end else if (is_wr) begin
            res_d = meter_cmd_pkg::len_code(flen, meter_cmd_pkg::LEN_WR,
                                            meter_cmd_pkg::RES_COUNT);
            if (res_d != meter_cmd_pkg::RES_OK)
                res_d = res_d;
            else if (vtype == meter_cmd_pkg::VT_C0)
                res_d = meter_cmd_pkg::RES_RDONLY;
            else if (vtype < meter_cmd_pkg::VT_C1 || vtype > meter_cmd_pkg::VT_C3)
                res_d = meter_cmd_pkg::RES_VTYPE;
            else if (!fields_ok)
                res_d = meter_cmd_pkg::RES_PARAM;
            else if (vtype == meter_cmd_pkg::VT_C2 && vaddr != meter_cmd_pkg::VA_REMOTE)
                res_d = meter_cmd_pkg::RES_ADDR;
            else if (calib_level || !write_permit)
                res_d = meter_cmd_pkg::RES_OPERR;
            else if (vtype == meter_cmd_pkg::VT_C3 && !setting_area)
                res_d = meter_cmd_pkg::RES_OPERR;
            else if (vtype == meter_cmd_pkg::VT_C1 && (setting_area || !protect_level))
                res_d = meter_cmd_pkg::RES_OPERR;
            else if (vtype != meter_cmd_pkg::VT_C2 && nvm_fail)
                res_d = meter_cmd_pkg::RES_OPERR;
            else
                res_d = meter_cmd_pkg::RES_OK;
        end
    end

    // ****************************************
    // Response registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            resp_q  <= 32'h00000000;
            rdata_q <= 32'h00000000;
        end else if (exec) begin
            resp_q  <= {code_q, res_d};
            rdata_q <= rdat_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst)
            done_q <= 1'b0;
        else if (exec)
            done_q <= 1'b1;
        else if (go && state_q == meter_cmd_pkg::ST_IDLE)
            done_q <= 1'b0;
    end

    // ****************************************
    // Device state
    // ****************************************
    logic op_ok;
    logic wr_ok;

    assign op_ok = exec && is_op && (op_res == meter_cmd_pkg::RES_OK);
    assign wr_ok = exec && is_wr && (res_d == meter_cmd_pkg::RES_OK);

    always_ff @(posedge clock) begin
        if (rst) begin
            setting_area   <= 1'b0;
            init_level_ind <= 1'b0;
            protect_level  <= 1'b0;
        end else if (op_ok && vtype == meter_cmd_pkg::INS_SRESET) begin
            setting_area   <= 1'b0;
            init_level_ind <= 1'b0;
            protect_level  <= 1'b0;
        end else begin
            if (panel_init || (op_ok && vtype == meter_cmd_pkg::INS_AREA1)) begin
                setting_area   <= 1'b1;
                init_level_ind <= 1'b1;
            end
            if (op_ok && vtype == meter_cmd_pkg::INS_PROTECT)
                protect_level <= 1'b1;
        end
    end

    assign measuring = !setting_area;

    always_ff @(posedge clock) begin
        if (rst) begin
            write_permit <= 1'b0;
            forced_zero  <= 1'b0;
            soft_reset   <= 1'b0;
        end else begin
            soft_reset <= op_ok && (vtype == meter_cmd_pkg::INS_SRESET);
            if (op_ok && vtype == meter_cmd_pkg::INS_PERMIT)
                write_permit <= related[0];
            if (op_ok && vtype == meter_cmd_pkg::INS_FZERO)
                forced_zero <= related[0];
        end
    end

    // Display keeps its last value while measurement is suspended
    always_ff @(posedge clock) begin
        if (rst)
            display_value <= 32'h00000000;
        else if (wr_ok && vtype == meter_cmd_pkg::VT_C2 && !setting_area)
            display_value <= wdata_q;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            param_wr   <= 1'b0;
            param_sel  <= 24'h000000;
            param_data <= 32'h00000000;
        end else begin
            param_wr <= wr_ok && (vtype != meter_cmd_pkg::VT_C2);
            if (wr_ok) begin
                param_sel  <= {vtype, vaddr};
                param_data <= wdata_q;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_start;
        go && state_q == meter_cmd_pkg::ST_IDLE;
    endsequence
    sequence s_answer;
        exec ##1 (done_q && state_q == meter_cmd_pkg::ST_REPLY);
    endsequence

    AST_ONE_REPLY: assert property (@(posedge clock) disable iff (rst)
        s_start |=> s_answer) else $error("request not answered once");
    AST_ECHO: assert property (@(posedge clock) disable iff (rst)
        exec |=> resp_q[31:16] == $past(code_q)) else $error("code not echoed");
    AST_LONG: assert property (@(posedge clock) disable iff (rst)
        exec && is_op && flen > meter_cmd_pkg::LEN_OP
        |=> resp_q[15:0] == meter_cmd_pkg::RES_LONG) else $error("long not 1001");
    AST_SHORT: assert property (@(posedge clock) disable iff (rst)
        exec && is_op && flen < meter_cmd_pkg::LEN_OP
        |=> resp_q[15:0] == meter_cmd_pkg::RES_SHORT) else $error("short not 1002");
    AST_NO_PERMIT: assert property (@(posedge clock) disable iff (rst)
        exec && is_op && !write_permit && vtype == meter_cmd_pkg::INS_FZERO
        && flen == meter_cmd_pkg::LEN_OP && related[7:1] == 7'h00
        |=> resp_q[15:0] == meter_cmd_pkg::RES_OPERR && $stable(forced_zero))
        else $error("forced-zero ran without permission");
    AST_AREA_HOLD: assert property (@(posedge clock) disable iff (rst)
        setting_area && !(op_ok && vtype == meter_cmd_pkg::INS_SRESET)
        |=> setting_area) else $error("left area 1 without reset");
    AST_PV_UNKNOWN: assert property (@(posedge clock) disable iff (rst)
        exec && is_rd && setting_area && res_d == meter_cmd_pkg::RES_OK
        |=> rdata_q == meter_cmd_pkg::UNKNOWN_DAT) else $error("area 1 read leaked");
    AST_DISPLAY: assert property (@(posedge clock) disable iff (rst)
        setting_area |=> $stable(display_value)) else $error("display moved in area 1");
    AST_POWER_ON: assert property (@(posedge clock)
        rst |=> !setting_area && !write_permit) else $error("bad power-on area");
endmodule // meter_operation_command_handler
`default_nettype wire

// *** tb/host_model.sv ***
`default_nettype none
module host_model (
    input  wire logic        clock,
    input  wire logic        ack_o,
    input  wire logic [31:0] dat_o,
    output var  logic        cyc,
    output var  logic        stb,
    output var  logic        we,
    output var  logic [7:0]  adr,
    output var  logic [31:0] dat
);
    timeunit 1ns;
    timeprecision 1ns;
    logic timed_out = 1'b0;
    initial {cyc, stb, we, adr, dat} = '0;
    // ************************
    // Single classic cycle, held until ack
    // ************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin @(posedge clock); n++; end while (ack_o !== 1'b1 && n < 64);
        q = dat_o;
        if (n >= 64) timed_out = 1'b1;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    // ************************
    // One frame, one reply, then the next
    // ************************
    task automatic cmd(input logic [15:0] code, input logic [31:0] arg, input logic [15:0] len,
                       input logic [31:0] wd, output logic [31:0] rsp, output logic [31:0] rd);
        logic [31:0] q;
        int n;
        wb(1'b1, 8'h04, {16'h0000, code}, q);
        wb(1'b1, 8'h08, arg, q);
        wb(1'b1, 8'h0c, {16'h0000, len}, q);
        wb(1'b1, 8'h10, wd, q);
        wb(1'b1, 8'h00, 32'h00000001, q);
        n = 0;
        do begin wb(1'b0, 8'h1c, 32'h0, q); n++; end while (q[4] !== 1'b1 && n < 16);
        if (n >= 16) timed_out = 1'b1;
        wb(1'b0, 8'h14, 32'h0, rsp);
        wb(1'b0, 8'h18, 32'h0, rd);
    endtask
endmodule // host_model
`default_nettype wire

// *** tb/meter_operation_command_handler_tb.sv ***
`default_nettype none
module meter_operation_command_handler_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, rst, panel_init, calib_level, nvm_fail, cyc, stb, we, ack_o;
    logic        area, meas, permit, fz, prot, ind, srst, pwr;
    logic [7:0]  adr;
    logic [23:0] psel;
    logic [31:0] pv, cs, dat, dat_o, disp, pdata, rsp, rd, w;
    int          seed, err_count, comparisons, pw_n, sr_n;
    host_model u_host (.clock(clock), .ack_o(ack_o), .dat_o(dat_o), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .dat(dat));
    meter_operation_command_handler u_dut (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .panel_init(panel_init), .calib_level(calib_level), .nvm_fail(nvm_fail),
        .process_value(pv), .comp_status(cs), .setting_area(area), .measuring(meas),
        .write_permit(permit), .forced_zero(fz), .protect_level(prot), .init_level_ind(ind),
        .soft_reset(srst), .display_value(disp), .param_wr(pwr), .param_sel(psel),
        .param_data(pdata));
    always #25 clock = ~clock;
    // ************************
    // Checking and closing
    // ************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin err_count++; $display("ERROR %0t: got %h expected %h", $time, got, exp); end
    endtask
    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) if (u_host.timed_out === 1'b1) begin err_count++; summarize(); end
    // One-cycle pulses are counted here, the bench looks much later
    always @(posedge clock) begin
        if (pwr === 1'b1) pw_n++;
        if (srst === 1'b1) sr_n++;
    end
    task automatic op(input logic [7:0] i, input logic [7:0] r, input logic [7:0] l,
                      input logic [15:0] e);
        u_host.cmd(16'h3005, {16'h0000, r, i}, {8'h00, l}, 32'h0, rsp, rd);
        chk(rsp, {meter_cmd_pkg::MAIN_OP, meter_cmd_pkg::SUB_OP, e});
    endtask
    task automatic rdv(input logic [15:0] a, input logic [31:0] e);
        u_host.cmd(16'h0101, {a, 16'h00c0}, 16'h0110, 32'h0, rsp, rd);
        chk(rsp, 32'h01010000);
        chk(rd, e);
    endtask
    task automatic wrv(input logic [31:0] d, input logic [31:0] e);
        u_host.cmd(16'h0102, 32'h000000c2, 16'h0118, d, rsp, rd);
        chk(rsp, 32'h01020000);
        chk(disp, e);
    endtask
    task automatic wrp(input logic [7:0] t, input logic [31:0] d, input logic [15:0] e);
        u_host.cmd(16'h0102, {24'h000000, t}, 16'h0118, d, rsp, rd);
        chk(rsp, {16'h0102, e});
    endtask
    // ************************
    // Main sequence
    // ************************
    initial begin
        seed = 32'he5086292;
        {clock, panel_init, calib_level, nvm_fail, err_count, comparisons, pw_n, sr_n} = '0;
        rst = 1'b1;
        pv = $random(seed);
        cs = $random(seed);
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk({area, prot, ind, fz, permit, meas}, 6'h01);
        op(8'h03, 8'h01, 8'h08, 16'h2203);
        chk(fz, 1'b0);
        op(8'h00, 8'h01, 8'h09, 16'h1001);
        op(8'h00, 8'h01, 8'h07, 16'h1002);
        op(8'h05, 8'h00, 8'h08, 16'h1100);
        op(8'h00, 8'h02, 8'h08, 16'h1100);
        nvm_fail <= 1'b1;
        op(8'h00, 8'h01, 8'h08, 16'h2203);
        nvm_fail <= 1'b0;
        op(8'h00, 8'h01, 8'h08, 16'h0000);
        chk(permit, 1'b1);
        op(8'h03, 8'h01, 8'h08, 16'h0000);
        chk(fz, 1'b1);
        rdv(16'h0001, pv);
        rdv(16'h0002, cs);
        repeat (3) begin w = $random(seed); wrv(w, w); end
        op(8'h08, 8'h00, 8'h08, 16'h0000);
        chk(prot, 1'b1);
        wrp(8'hc1, w, 16'h0000);
        chk(pw_n, 32'd1);
        chk(psel, 24'hc10000);
        chk(pdata, w);
        wrp(8'hc3, w, 16'h2203);
        op(8'h07, 8'h00, 8'h08, 16'h0000);
        chk({area, meas, ind}, 3'b101);
        op(8'h03, 8'h00, 8'h08, 16'h2203);
        rdv(16'h0001, 32'hffffffff);
        rdv(16'h0002, 32'hffffffff);
        wrp(8'hc3, ~w, 16'h0000);
        wrp(8'hc1, w, 16'h2203);
        chk(pw_n, 32'd2);
        chk(pdata, ~w);
        wrv(~w, w);
        op(8'h06, 8'h00, 8'h08, 16'h0000);
        chk({area, meas}, 2'b01);
        chk({sr_n[1:0], prot}, 3'b010);
        calib_level <= 1'b1;
        op(8'h07, 8'h00, 8'h08, 16'h2203);
        calib_level <= 1'b0;
        panel_init <= 1'b1;
        @(posedge clock);
        panel_init <= 1'b0;
        @(posedge clock);
        chk(area, 1'b1);
        summarize();
    end
endmodule // meter_operation_command_handler_tb
`default_nettype wire
